// ==== core/temp_sensor_pkg.sv ====
// Purpose: constants shared by the temperature sensor register file
// Assumes: 100 MHz system clock, two-wire serial bus on scl/sda pins
// Notes: register index, configuration field positions, reset values, timing
//
// Notes on behaviour
// - pointer low two bits read/write, reset zero
// - pointer bits two to seven read zero
// - data access goes to pointer-selected register
// - temperature result at 0x0, writes ignored
// - all other registers readable and writable
// - configuration register at address 0x1
// - lower threshold at address 0x2
// - upper threshold at address 0x3
// - rate select gives 0.25/1/4/8 conversions per second
// - config bits 7:6 rate select, reset 10
// - config bit 8 sleep enable, reset 0
// - config bit 9 comparator/interrupt select, reset 0; the code stores and reads it back but the alert logic ignores it
// - config bits 12:11 fault count, reset 00
// - sixteen-bit registers move high byte first
// - flag toggles after N faults past thresholds
// - single shot in sleep, bit 15 reads busy
// - sleep halts conversions, clearing resumes them
package temp_sensor_pkg;
  localparam logic [1:0] ADDR_RESULT = 2'h0;
  localparam logic [1:0] ADDR_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_LOWER  = 2'h2;
  localparam logic [1:0] ADDR_UPPER  = 2'h3;
  localparam int CFG_FLAG_BIT   = 5;
  localparam int CFG_RATE_LSB   = 6;
  localparam int CFG_SLEEP_BIT  = 8;
  localparam int CFG_IRQ_BIT    = 9;
  localparam int CFG_LEVEL_BIT  = 10;
  localparam int CFG_FAULT_LSB  = 11;
  localparam int CFG_SHOT_BIT   = 15;
  localparam logic [15:0] CFG_FIXED_MASK = 16'h4000; // reserved bit 14 reads 1
  localparam logic [1:0]  RATE_RESET     = 2'h2;
  localparam logic [15:0] LOWER_RESET    = 16'h0000;
  localparam logic [15:0] UPPER_RESET    = 16'h0000;
  localparam int CLOCK_MHZ       = 100;
  localparam int CONV_TIME_MS    = 36;
  localparam int CONV_MIN_MS     = 22;
  localparam int CONV_MAX_MS     = 51;
  localparam int CONV_CYCLES     = CONV_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int PERIOD_4S_MS    = 4000;
  localparam int PERIOD_1S_MS    = 1000;
  localparam int PERIOD_250MS_MS = 250;
  localparam int PERIOD_125MS_MS = 125;
  localparam int PERIOD_4S_CYC   = PERIOD_4S_MS * 1000 * CLOCK_MHZ;
  localparam int PERIOD_1S_CYC   = PERIOD_1S_MS * 1000 * CLOCK_MHZ;
  localparam int PERIOD_250_CYC  = PERIOD_250MS_MS * 1000 * CLOCK_MHZ;
  localparam int PERIOD_125_CYC  = PERIOD_125MS_MS * 1000 * CLOCK_MHZ;
  localparam logic [6:0] DEVICE_ADDR = 7'h48; // arbitrary default bus address
endpackage

// ==== core/serial_slave.sv ====
// Purpose: two-wire serial bus slave, byte level, for the register file
// Assumes: scl and sda already passed two flip-flops on clock
// Notes: stretches no clock; repeated start supported
`timescale 1ns/100ps
`default_nettype none
module serial_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // synchronised pins
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  output logic            sda_drive_low,
  // byte side
  output logic            wr_valid,     // one-cycle pulse per written byte
  output logic            wr_first,     // byte is first after address
  output logic [7:0]      wr_byte,
  output logic            rd_req,       // pulse: next read byte needed
  input  wire logic [7:0] rd_byte,
  output logic            frame_start   // pulse on start or repeated start
);
  typedef enum {IDLE, ADDR, ACK, WRITE, READ, RACK} state_type;
  state_type  state_q;
  logic       scl_q, sda_q, rd_dir_q, first_q;
  logic [7:0] shift_q;
  logic [3:0] count_q;
  logic       rise, fall, start_c, stop_c;

  assign rise    = scl_s && !scl_q;
  assign fall    = !scl_s && scl_q;
  assign start_c = scl_s && scl_q && sda_q && !sda_s;
  assign stop_c  = scl_s && scl_q && !sda_q && sda_s;

  // edge history
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // byte engine
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= IDLE; shift_q <= 8'h00; count_q <= 4'h0;
      rd_dir_q <= 1'b0; first_q <= 1'b0; sda_drive_low <= 1'b0;
      wr_valid <= 1'b0; wr_first <= 1'b0; wr_byte <= 8'h00;
      rd_req <= 1'b0; frame_start <= 1'b0;
    end
    else
    begin
      wr_valid    <= 1'b0;
      rd_req      <= 1'b0;
      frame_start <= 1'b0;
      if (start_c)
      begin
        state_q <= ADDR; count_q <= 4'h0; sda_drive_low <= 1'b0;
        frame_start <= 1'b1;
      end
      else if (stop_c)
      begin
        state_q <= IDLE; sda_drive_low <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          IDLE: ;
          ADDR, WRITE:
          begin
            if (rise)
            begin
              shift_q <= {shift_q[6:0], sda_s};
              count_q <= count_q + 4'h1;
            end
            if (fall && count_q == 4'h8)
            begin
              count_q <= 4'h0;
              if (state_q == ADDR)
              begin
                if (shift_q[7:1] == DEV_ADDR)
                begin
                  rd_dir_q <= shift_q[0]; first_q <= 1'b1;
                  sda_drive_low <= 1'b1; state_q <= ACK;
                  rd_req <= shift_q[0];
                end
                else
                  state_q <= IDLE;
              end
              else
              begin
                wr_valid <= 1'b1; wr_first <= first_q; wr_byte <= shift_q;
                first_q <= 1'b0; sda_drive_low <= 1'b1; state_q <= ACK;
              end
            end
          end
          ACK:
          begin
            if (fall)
            begin
              if (rd_dir_q)
              begin
                shift_q <= {rd_byte[6:0], 1'b0};
                sda_drive_low <= !rd_byte[7];
                count_q <= 4'h1; state_q <= READ;
              end
              else
              begin
                sda_drive_low <= 1'b0; state_q <= WRITE;
              end
            end
          end
          READ:
          begin
            if (fall)
            begin
              if (count_q == 4'h8)
              begin
                sda_drive_low <= 1'b0; count_q <= 4'h0; state_q <= RACK;
              end
              else
              begin
                sda_drive_low <= !shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                count_q <= count_q + 4'h1;
              end
            end
          end
          RACK:
          begin
            if (rise)
            begin
              if (sda_s)
                state_q <= IDLE; // host nack ends reading
              else
                rd_req <= 1'b1;
            end
            if (fall)
            begin
              // next byte goes out at once, its first bit on this fall
              shift_q <= {rd_byte[6:0], 1'b0};
              sda_drive_low <= !rd_byte[7];
              count_q <= 4'h1; state_q <= READ;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/temp_sensor_register_file.sv ====
// Purpose: register file and conversion timing of a digital temperature sensor
// Assumes: pins scl/sda asynchronous to clock; sample arrives from converter
// Notes: sda is open drain, sda_oe high pulls the line low
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_register_file #(
  parameter int CONV_CYC = temp_sensor_pkg::CONV_CYCLES,
  parameter int P4S_CYC  = temp_sensor_pkg::PERIOD_4S_CYC,
  parameter int P1S_CYC  = temp_sensor_pkg::PERIOD_1S_CYC,
  parameter int P250_CYC = temp_sensor_pkg::PERIOD_250_CYC,
  parameter int P125_CYC = temp_sensor_pkg::PERIOD_125_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // converter side
  input  wire logic [15:0] sample_value,  // same-clock converter output
  output logic             converting,    // high while a conversion runs
  // alert pin, open drain
  output logic             alert_out,
  output logic             alert_oe
);
  // refuse a conversion that could not end inside the shortest period
  if (CONV_CYC < 1 || P125_CYC <= CONV_CYC)
  begin : g_timing_check
    $error("conversion timing parameters out of range");
  end

  logic        scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic        sda_low;
  logic        wr_valid, wr_first, rd_req, frame_start;
  logic [7:0]  wr_byte;
  logic [1:0]  ptr_q;
  logic        byte_hi_q;
  logic [15:0] result_q, lower_q, upper_q, hold_q, read_word;
  logic [7:0]  rd_byte_q;
  logic [1:0]  rate_q, fault_sel_q;
  logic        sleep_q, irq_q, level_q, shot_q, flag_q;
  logic [31:0] conv_cnt_q, period_cnt_q, period_len, conv_age_q;
  logic        conv_done;
  logic [2:0]  fault_cnt_q;

  // two-flop synchronisers for the bus pins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_m_q <= 1'b1; scl_s_q <= 1'b1; sda_m_q <= 1'b1; sda_s_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_in; scl_s_q <= scl_m_q;
      sda_m_q <= sda_in; sda_s_q <= sda_m_q;
    end
  end

  serial_slave #(
    .DEV_ADDR (temp_sensor_pkg::DEVICE_ADDR)
  ) u_slave (
    .clock         (clock),
    .rst_n         (rst_n),
    .scl_s         (scl_s_q),
    .sda_s         (sda_s_q),
    .sda_drive_low (sda_low),
    .wr_valid      (wr_valid),
    .wr_first      (wr_first),
    .wr_byte       (wr_byte),
    .rd_req        (rd_req),
    .rd_byte       (rd_byte_q),
    .frame_start   (frame_start)
  );

  // pin drive, registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out <= 1'b0; sda_oe <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe  <= sda_low;
    end
  end

  // pointer and byte phase
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_q <= 2'h0; byte_hi_q <= 1'b1;
    end
    else if (frame_start)
      byte_hi_q <= 1'b1;
    else if (wr_valid && wr_first)
    begin
      ptr_q     <= wr_byte[1:0];
      byte_hi_q <= 1'b1;
    end
    else if (wr_valid || rd_req)
      byte_hi_q <= !byte_hi_q;
  end

  // word readback from the selected register
  always_comb
  begin
    unique case (ptr_q)
      temp_sensor_pkg::ADDR_RESULT: read_word = result_q;
      temp_sensor_pkg::ADDR_CONFIG: read_word = temp_sensor_pkg::CFG_FIXED_MASK
        | {shot_q, 2'b00, fault_sel_q, level_q, irq_q, sleep_q, rate_q, flag_q, 5'h00};
      temp_sensor_pkg::ADDR_LOWER:  read_word = lower_q;
      temp_sensor_pkg::ADDR_UPPER:  read_word = upper_q;
    endcase
  end

  // read byte, high first; low half latched with the high half
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_byte_q <= 8'h00; hold_q <= 16'h0000;
    end
    else if (rd_req)
    begin
      if (byte_hi_q)
      begin
        rd_byte_q <= read_word[15:8];
        hold_q    <= read_word;
      end
      else
        rd_byte_q <= hold_q[7:0];
    end
    else if (wr_valid && !wr_first && byte_hi_q)
      hold_q[15:8] <= wr_byte; // staged high byte of a write
  end

  // writable registers, high byte staged until low byte arrives
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_q <= temp_sensor_pkg::RATE_RESET;
      sleep_q <= 1'b0; irq_q <= 1'b0; level_q <= 1'b0;
      fault_sel_q <= 2'h0;
      lower_q <= temp_sensor_pkg::LOWER_RESET;
      upper_q <= temp_sensor_pkg::UPPER_RESET;
      shot_q <= 1'b0;
    end
    else
    begin
      if (conv_done)
        shot_q <= 1'b0;
      if (wr_valid && !wr_first && !byte_hi_q)
      begin
        unique case (ptr_q)
          temp_sensor_pkg::ADDR_RESULT: ;
          temp_sensor_pkg::ADDR_CONFIG:
          begin
            rate_q      <= wr_byte[7:6];
            sleep_q     <= hold_q[8];
            irq_q       <= hold_q[9];
            level_q     <= hold_q[10];
            fault_sel_q <= hold_q[12:11];
            if (hold_q[15] && sleep_q && !shot_q)
              shot_q <= 1'b1;
          end
          temp_sensor_pkg::ADDR_LOWER: lower_q <= {hold_q[15:8], wr_byte};
          temp_sensor_pkg::ADDR_UPPER: upper_q <= {hold_q[15:8], wr_byte};
        endcase
      end
    end
  end

  // hold_q serves both directions: a frame either reads or writes, never both

  // period selected by rate
  always_comb
  begin
    unique case (rate_q)
      2'h0: period_len = P4S_CYC;
      2'h1: period_len = P1S_CYC;
      2'h2: period_len = P250_CYC;
      2'h3: period_len = P125_CYC;
    endcase
  end

  // conversion timer and period scheduler
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_cnt_q <= 32'h0000_0001; // a conversion starts at power-on
      period_cnt_q <= 32'h0000_0000;
      converting <= 1'b1;
      result_q <= 16'h0000;
    end
    else
    begin
      period_cnt_q <= (period_cnt_q + 32'h1 >= period_len) ? 32'h0 : period_cnt_q + 32'h1;
      if (converting)
      begin
        if (conv_done)
        begin
          converting <= 1'b0;
          result_q   <= sample_value;
        end
        else
          conv_cnt_q <= conv_cnt_q + 32'h1;
      end
      else if ((!sleep_q && period_cnt_q == 32'h0) || (shot_q && sleep_q))
      begin
        converting <= 1'b1;
        conv_cnt_q <= 32'h0000_0001;
      end
    end
  end
  assign conv_done = converting && conv_cnt_q >= 32'(CONV_CYC);

  // overtemp flag with consecutive fault counting, active level aware
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b1; fault_cnt_q <= 3'h0;
      alert_out <= 1'b0; alert_oe <= 1'b0;
    end
    else
    begin
      if (conv_done)
      begin
        if ((flag_q != level_q) ? ($signed(sample_value) > $signed(upper_q))
                                : ($signed(sample_value) < $signed(lower_q)))
        begin
          if (fault_cnt_q >= {1'b0, fault_sel_q})
          begin
            flag_q <= !flag_q; fault_cnt_q <= 3'h0;
          end
          else
            fault_cnt_q <= fault_cnt_q + 3'h1;
        end
        else
          fault_cnt_q <= 3'h0;
      end
      alert_out <= 1'b0;
      alert_oe  <= !flag_q; // pin pulled low while the flag reads 0
    end
  end

  // age of the running conversion, for the bound check below
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      conv_age_q <= 32'h0000_0000;
    else
      conv_age_q <= converting ? conv_age_q + 32'h1 : 32'h0000_0000;
  end

  // every conversion must end within its conversion time
  AST_CONV_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
    converting |-> conv_age_q < 32'(CONV_CYC))
    else $error("conversion did not finish");
  AST_PTR_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_valid && wr_first) |=> ptr_q == $past(wr_byte[1:0]))
    else $error("pointer not loaded from first byte");
  AST_RESULT_RO: assert property (@(posedge clock) disable iff (!rst_n)
    !conv_done |=> result_q == $past(result_q))
    else $error("result changed without conversion");
  AST_SLEEP_HALT: assert property (@(posedge clock) disable iff (!rst_n)
    (sleep_q && !shot_q && !converting) |=> !converting)
    else $error("conversion started while sleeping");
  AST_SHOT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    (shot_q && conv_done) |=> !shot_q)
    else $error("single shot bit not cleared");
  AST_RESULT_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    conv_done |=> result_q == $past(sample_value))
    else $error("result not refreshed");
  AST_SYNC_SDA: assert property (@(posedge clock) disable iff (!rst_n)
    sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (!conv_done && level_q == $past(level_q)) |=> flag_q == $past(flag_q))
    else $error("flag moved without conversion");
endmodule
`default_nettype wire

// ==== tb/serial_host_model.sv ====
// Purpose: two-wire bus host that drives the register file from the bench
// Assumes: sda_line is the resolved wire level with its pull-up
// Notes: scl stands high between frames; bit period alternates 12 and 13 cycles
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  // clock
  input  wire logic        clock,
  // bus wires
  output logic             scl,
  output logic             sda_pull,
  input  wire logic        sda_line,
  // read results
  output logic [15:0]      rd_word,
  output logic             rd_valid
);
  logic phase;

  // idle bus at time zero
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_word = 16'h0000;
    rd_valid = 1'b0;
    phase = 1'b0;
  end

  // step n clock edges, then move just off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one bit out, one bit back sampled at the end of scl high
  task automatic bit_io(input logic b, output logic r);
    cyc(3);
    sda_pull = !b;
    cyc(3);
    scl = 1'b1;
    cyc(6 + int'(phase));
    phase = !phase;
    r = sda_line;
    scl = 1'b0;
  endtask

  // start: sda falls while scl high
  task automatic frame_start();
    sda_pull = 1'b0;
    cyc(3);
    scl = 1'b1;
    cyc(6);
    sda_pull = 1'b1;
    cyc(6);
    scl = 1'b0;
  endtask

  // stop: sda rises while scl high, then scl stands still
  task automatic frame_stop();
    cyc(3);
    sda_pull = 1'b1;
    cyc(3);
    scl = 1'b1;
    cyc(6);
    sda_pull = 1'b0;
    cyc(6);
  endtask

  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic byte_in(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask

  // address byte alone, to probe a foreign address
  task automatic addr_probe(input logic [6:0] a, output logic ack);
    frame_start();
    byte_out({a, 1'b0}, ack);
    frame_stop();
  endtask

  // pointer byte first, then an optional word high byte first
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] w,
                           input logic with_data, output logic ok);
    logic a0, a1, a2, a3;
    frame_start();
    byte_out({temp_sensor_pkg::DEVICE_ADDR, 1'b0}, a0);
    byte_out(ptr, a1);
    a2 = 1'b1;
    a3 = 1'b1;
    if (with_data)
    begin
      byte_out(w[15:8], a2);
      byte_out(w[7:0], a3);
    end
    frame_stop();
    ok = a0 & a1 & a2 & a3;
  endtask

  // read the word at the current pointer, high byte first
  task automatic read_cur(output logic ok);
    logic [7:0] hi, lo;
    frame_start();
    byte_out({temp_sensor_pkg::DEVICE_ADDR, 1'b1}, ok);
    byte_in(1'b0, hi);
    byte_in(1'b1, lo);
    frame_stop();
    rd_word = {hi, lo};
    rd_valid = 1'b1;
    cyc(1);
    rd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_temp_sensor_register_file.sv ====
// Purpose: self-checking bench of the temperature sensor register file
// Assumes: shortened conversion and period counts
// Notes: reads are noted in a queue and checked when the host returns a word
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_temp_sensor_register_file;
  localparam int CONV    = 20;
  localparam int PER [4] = '{800, 400, 200, 100};
  logic        clock, rst_n, scl, host_pull, sda_oe, sda_out;
  logic        alert_out, alert_oe, converting, rd_valid, ok;
  logic [15:0] sample_value, rd_word, s, w, expv;
  logic [15:0] exp_q [$];
  int          fail_count, total_checks, seed, n, len, c;
  wire         sda_line;

  // open-drain wire with pull-up
  assign sda_line = !(host_pull || sda_oe);

  // clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  temp_sensor_register_file #(.CONV_CYC(CONV), .P4S_CYC(800), .P1S_CYC(400),
    .P250_CYC(200), .P125_CYC(100)) i_dut (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .sample_value(sample_value),
    .converting(converting), .alert_out(alert_out), .alert_oe(alert_oe));

  serial_host_model i_host (
    .clock(clock), .scl(scl), .sda_pull(host_pull), .sda_line(sda_line),
    .rd_word(rd_word), .rd_valid(rd_valid));

  // compare each returned word with the oldest note
  always @(posedge clock)
  begin
    if (rd_valid === 1'b1)
    begin
      expv = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_word;
      `CHK(rd_word, expv)
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic with_data);
    i_host.write_reg(p, d, with_data, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
    wr(p, 16'h0000, 1'b0);
    exp_q.push_back(e);
    i_host.read_cur(ok);
    `CHK(ok, 1'b1)
  endtask

  // bounded wait for converting to reach a level
  task automatic wait_lvl(input logic lvl, output int k);
    k = 0;
    while (converting !== lvl)
    begin
      @(posedge clock);
      #1;
      k++;
      if (k > 3000)
      begin
        `CHK(converting, lvl)
        final_report();
      end
    end
  endtask

  task automatic count_rises(input int cycles, output int k);
    logic prev;
    k = 0;
    prev = converting;
    repeat (cycles)
    begin
      @(posedge clock);
      #1;
      if (converting === 1'b1 && prev === 1'b0) k++;
      prev = converting;
    end
  endtask

  // main sequence
  initial
  begin
    seed = 32'hd4109f4c;
    s = 16'h8001 | 16'($random(seed));
    sample_value = s;
    rst_n = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (40) @(posedge clock);
    #1;
    exp_q.push_back(s);
    i_host.read_cur(ok);
    `CHK(ok, 1'b1)
    i_host.addr_probe(temp_sensor_pkg::DEVICE_ADDR ^ 7'h01, ok);
    `CHK(ok, 1'b0)
    rd_chk(8'hFD, 16'h40A0);
    rd_chk(8'h02, temp_sensor_pkg::LOWER_RESET);
    rd_chk(8'h03, temp_sensor_pkg::UPPER_RESET);
    $display("reset values done");
    for (int a = 2; a < 4; a++)
    begin
      w = 16'($random(seed)) & 16'h7FFF;
      wr(8'(a), w, 1'b1);
      rd_chk(8'(a), w);
    end
    wr(8'h02, 16'h8000, 1'b1); // lowest threshold keeps the flag still
    wr(8'h00, ~s, 1'b1);
    rd_chk(8'h00, s);
    w = 16'($random(seed)) & 16'h7EFF;
    wr(8'h01, w, 1'b1);
    rd_chk(8'h01, (w & 16'h1FC0) | 16'h4020);
    $display("access done");
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h01, 16'(k) << 6, 1'b1);
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, len);
      `CHK(len, CONV)
      wait_lvl(1'b1, n);
      `CHK(len + n, PER[k])
    end
    $display("rates done");
    wr(8'h01, 16'h0100, 1'b1);
    repeat (40) @(posedge clock);
    #1;
    count_rises(1000, c);
    `CHK(c, 0)
    fork
      count_rises(1500, c);
      wr(8'h01, 16'h8100, 1'b1);
    join
    `CHK(c, 1)
    rd_chk(8'h01, 16'h4120);
    wr(8'h01, 16'h0080, 1'b1);
    count_rises(1000, c);
    `CHK(c > 3, 1'b1)
    $display("sleep done");
    wr(8'h03, s - 16'h0001, 1'b1);
    repeat (2)
    begin
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
    end
    rd_chk(8'h01, 16'h4080);
    `CHK(alert_oe, 1'b1)
    wr(8'h03, 16'h7FFF, 1'b1);
    wr(8'h02, 16'h7FFE, 1'b1); // result now below the lower threshold
    repeat (2)
    begin
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
    end
    rd_chk(8'h01, 16'h40A0);
    `CHK(alert_oe, 1'b0)
    $display("alert done");
    final_report();
  end
endmodule
`default_nettype wire
